// ===== hdl/seac_host.sv
// host end: drives scl from a divider, runs byte writes and reads
// read bytes queue in a fifo; a full fifo holds scl low before a byte
`timescale 1ns/1ps
module seac_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wp, rp, next_wp, next_rp;

    assign in_ready = (wp[AW-1:0] != rp[AW-1:0]) || (wp[AW] == rp[AW]);
    assign out_valid = (wp != rp);
    assign out_data = mem[rp[AW-1:0]];

    always_comb begin
        next_wp = wp + (AW+1)'(in_valid && in_ready);
        next_rp = rp + (AW+1)'(out_valid && out_ready);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (in_valid && in_ready) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end
endmodule

module seac_host
    import seac_pkg::*;
#(
    parameter int PHASE_CYCLES = SEAC_PHASE_CYCLES,
    parameter int FIFO_DEPTH = SEAC_FIFO_DEPTH,
    parameter logic [2:0] SELECT = 3'h0
) (
    input wire logic sys_clk,
    input wire logic resetn,
    seac_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [SEAC_ADDR_W-1:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] cmd_count,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data
);
    localparam int DW = $clog2(PHASE_CYCLES);
    localparam logic [DW-1:0] DIV_LAST = DW'(PHASE_CYCLES - 1);

    typedef enum logic [4:0] {
        M_IDLE = 5'b00001,
        M_START = 5'b00010,
        M_TX = 5'b00100,
        M_RX = 5'b01000,
        M_STOP = 5'b10000
    } seac_mst_t;

    seac_mst_t st, next_st;
    logic [DW-1:0] divc;
    logic tick;
    logic [1:0] ph, next_ph, step, next_step;
    logic [3:0] bitn, next_bitn;
    logic [7:0] sh, next_sh, remain, next_remain;
    logic [SEAC_ADDR_W-1:0] addr, next_addr;
    logic [7:0] wdata, next_wdata;
    logic op_rd, next_op_rd, polling, next_polling, again, next_again;
    logic nack, next_nack, scl, next_scl, sda_oe, next_oe, next_ready;
    logic push, next_push, fifo_ready;
    logic [1:0] sda_sync;

    assign tick = (divc == DIV_LAST);
    assign link.scl = scl;
    assign link.m_sda_oe = sda_oe;

    function automatic logic [7:0] tx_byte(input logic [1:0] s);
        unique case (s)
            2'h0: tx_byte = {SEAC_TYPE_ID, SELECT, 1'b0};
            2'h1: tx_byte = {4'h0, addr[11:8]};
            2'h2: tx_byte = addr[7:0];
            2'h3: tx_byte = op_rd ? {SEAC_TYPE_ID, SELECT, 1'b1} : wdata;
        endcase
    endfunction

    always_comb begin
        next_st = st;
        next_ph = ph;
        next_step = step;
        next_bitn = bitn;
        next_sh = sh;
        next_remain = remain;
        next_addr = addr;
        next_wdata = wdata;
        next_op_rd = op_rd;
        next_polling = polling;
        next_again = again;
        next_nack = nack;
        next_scl = scl;
        next_oe = sda_oe;
        next_ready = cmd_ready;
        next_push = 1'b0;
        if (st == M_IDLE) begin
            if (cmd_valid && cmd_ready) begin
                next_ready = 1'b0;
                next_addr = cmd_addr;
                next_wdata = cmd_wdata;
                next_op_rd = cmd_read;
                next_remain = (cmd_count == 8'h00) ? 8'h01 : cmd_count;
                next_step = 2'h0;
                next_polling = 1'b0;
                next_st = M_START;
                next_ph = 2'h0;
            end
        end else if (tick && !(st == M_RX && ph == 2'h0 && bitn == 4'h0 && !fifo_ready)) begin
            next_ph = ph + 1'b1;
            unique case (st)
                M_START: begin
                    unique case (ph)
                        2'h0: begin
                            next_scl = 1'b0;
                            next_oe = 1'b0;
                        end
                        2'h1: next_scl = 1'b1;
                        2'h2: next_oe = 1'b1;
                        2'h3: begin
                            next_scl = 1'b0;
                            next_sh = tx_byte(step);
                            next_bitn = 4'h0;
                            next_st = M_TX;
                        end
                    endcase
                end
                M_TX: begin
                    unique case (ph)
                        2'h0: next_oe = (bitn == SEAC_ACK_BIT) ? 1'b0 : ~sh[7];
                        2'h1: next_scl = 1'b1;
                        2'h2: next_nack = sda_sync[1];
                        2'h3: begin
                            next_scl = 1'b0;
                            next_sh = {sh[6:0], 1'b0};
                            next_bitn = bitn + 1'b1;
                            if (bitn == SEAC_ACK_BIT) begin
                                next_bitn = 4'h0;
                                if (nack) begin
                                    next_st = M_STOP;
                                    next_again = 1'b1;
                                    next_step = 2'h0;
                                end else if (polling) begin
                                    next_st = M_STOP;
                                    next_again = 1'b0;
                                end else if (step == 2'h2 && op_rd) begin
                                    next_st = M_START;
                                    next_step = 2'h3;
                                end else if (step == 2'h3 && op_rd) begin
                                    next_st = M_RX;
                                end else if (step == 2'h3) begin
                                    next_st = M_STOP;
                                    next_polling = 1'b1;
                                    next_again = 1'b1;
                                    next_step = 2'h0;
                                end else begin
                                    next_step = step + 1'b1;
                                    next_sh = tx_byte(step + 1'b1);
                                end
                            end
                        end
                    endcase
                end
                M_RX: begin
                    unique case (ph)
                        2'h0: next_oe = (bitn == SEAC_ACK_BIT) && (remain != 8'h01);
                        2'h1: next_scl = 1'b1;
                        2'h2: begin
                            if (bitn != SEAC_ACK_BIT) begin
                                next_sh = {sh[6:0], sda_sync[1]};
                            end
                        end
                        2'h3: begin
                            next_scl = 1'b0;
                            next_bitn = bitn + 1'b1;
                            next_push = (bitn == 4'h7);
                            if (bitn == SEAC_ACK_BIT) begin
                                next_bitn = 4'h0;
                                next_remain = remain - 1'b1;
                                if (remain == 8'h01) begin
                                    next_st = M_STOP;
                                    next_again = 1'b0;
                                end
                            end
                        end
                    endcase
                end
                M_STOP: begin
                    unique case (ph)
                        2'h0: begin
                            next_scl = 1'b0;
                            next_oe = 1'b1;
                        end
                        2'h1: next_scl = 1'b1;
                        2'h2: next_oe = 1'b0;
                        2'h3: begin
                            next_st = again ? M_START : M_IDLE;
                            next_ready = ~again;
                        end
                    endcase
                end
                default: next_st = M_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st <= M_IDLE;
            divc <= '0;
            ph <= 2'h0;
            step <= 2'h0;
            bitn <= 4'h0;
            sh <= 8'h00;
            remain <= 8'h00;
            addr <= '0;
            wdata <= 8'h00;
            op_rd <= 1'b0;
            polling <= 1'b0;
            again <= 1'b0;
            nack <= 1'b0;
            scl <= 1'b1;
            sda_oe <= 1'b0;
            cmd_ready <= 1'b1;
            push <= 1'b0;
            sda_sync <= 2'h3;
        end else begin
            st <= next_st;
            divc <= tick ? '0 : divc + 1'b1;
            ph <= next_ph;
            step <= next_step;
            bitn <= next_bitn;
            sh <= next_sh;
            remain <= next_remain;
            addr <= next_addr;
            wdata <= next_wdata;
            op_rd <= next_op_rd;
            polling <= next_polling;
            again <= next_again;
            nack <= next_nack;
            scl <= next_scl;
            sda_oe <= next_oe;
            cmd_ready <= next_ready;
            push <= next_push;
            sda_sync <= {sda_sync[0], link.sda};
        end
    end

    seac_fifo #(
        .W(SEAC_FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data(sh),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );
endmodule

// ===== common/seac_pkg.sv
// shared constants for the two-wire eeprom access ends
// assumes a single 250 MHz system clock on both ends
package seac_pkg;
    localparam int SEAC_ADDR_W = 12;
    localparam int SEAC_PAGE_W = 5;
    localparam int SEAC_DEPTH = 4096;
    localparam logic [3:0] SEAC_TYPE_ID = 4'h6; // arbitrary value
    localparam logic [7:0] SEAC_ERASED = 8'hff;
    localparam int SEAC_CLK_PERIOD_NS = 4;
    localparam int SEAC_WRITE_CYCLE_TIME_NS = 5000;
    localparam int SEAC_WRITE_CYCLES = SEAC_WRITE_CYCLE_TIME_NS / SEAC_CLK_PERIOD_NS;
    localparam int SEAC_PHASE_CYCLES = 8;
    localparam int SEAC_FIFO_DEPTH = 16;
    localparam int SEAC_FIFO_W = 8;
    localparam logic [5:0] SEAC_SYNC_RST = 6'h03;
    localparam logic [1:0] SEAC_PH_LAST = 2'h3;
    localparam logic [3:0] SEAC_ACK_BIT = 4'h8;
endpackage

// ===== common/seac_link_if.sv
// two-wire link between the host end and the eeprom end
// sda is open drain: low while either end enables its driver
`timescale 1ns/1ps
interface seac_link_if;
    logic scl;
    logic m_sda_oe;
    logic d_sda_oe;
    logic sda;
    assign sda = ~(m_sda_oe | d_sda_oe);
    modport host (output scl, output m_sda_oe, input sda);
    modport dev (input scl, input sda, output d_sda_oe);
endinterface

// ===== hdl/seac_dev.sv
// eeprom end: two-wire target, page buffer, self-timed write, array
// assumes scl, sda, wp and select pins are asynchronous to sys_clk
`timescale 1ns/1ps
module seac_dev
    import seac_pkg::*;
#(
    parameter int WRITE_CYCLES = SEAC_WRITE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic resetn,
    seac_link_if.dev link,
    input wire logic wp,
    input wire logic select_bit_zero,
    input wire logic select_bit_one,
    input wire logic select_bit_two,
    output logic write_busy
);
    localparam int BC_W = $clog2(WRITE_CYCLES + 1);
    localparam int PAGE_N = 1 << SEAC_PAGE_W;
    localparam logic [BC_W-1:0] PAGE_CNT = BC_W'(PAGE_N);

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_RX = 5'b00010,
        S_RXACK = 5'b00100,
        S_TX = 5'b01000,
        S_TXACK = 5'b10000
    } seac_dst_t;
    typedef enum logic [3:0] {
        K_DEV = 4'b0001,
        K_HI = 4'b0010,
        K_LO = 4'b0100,
        K_DATA = 4'b1000
    } seac_kind_t;

    logic [5:0] s1, s2;
    logic [1:0] s3;
    seac_dst_t st, next_st;
    seac_kind_t kind, next_kind;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sh, next_sh;
    logic [SEAC_ADDR_W-1:0] addr, next_addr;
    logic rw, next_rw, more, next_more, have_data, next_have, sda_oe, next_oe;
    logic [BC_W-1:0] busy_cnt, next_busy_cnt;
    logic [PAGE_N-1:0] pmask, next_pmask;
    logic [SEAC_ADDR_W-SEAC_PAGE_W-1:0] prow, next_prow;
    logic pbuf_we;
    logic [7:0] mem [SEAC_DEPTH];
    logic [7:0] pbuf [PAGE_N];
    logic [SEAC_PAGE_W-1:0] cidx;
    logic [7:0] rd_byte;
    logic scl, sda, rise, fall, start, stop, wp_s, match;

    assign scl = s2[0];
    assign sda = s2[1];
    assign wp_s = s2[2];
    assign rise = scl & ~s3[0];
    assign fall = ~scl & s3[0];
    assign start = scl & s3[0] & s3[1] & ~sda;
    assign stop = scl & s3[0] & ~s3[1] & sda;
    assign match = (sh[7:4] == SEAC_TYPE_ID) && (sh[3:1] == s2[5:3]);
    assign rd_byte = mem[addr];
    assign cidx = SEAC_PAGE_W'(busy_cnt - 1'b1);
    assign link.d_sda_oe = sda_oe;

    // erased state; the array has no reset of its own, only power
    initial begin
        for (int i = 0; i < SEAC_DEPTH; i++) begin
            mem[i] = SEAC_ERASED;
        end
    end

    always_comb begin
        next_st = st;
        next_kind = kind;
        next_cnt = cnt;
        next_sh = sh;
        next_addr = addr;
        next_rw = rw;
        next_more = more;
        next_have = have_data;
        next_oe = sda_oe;
        next_pmask = pmask;
        next_prow = prow;
        pbuf_we = 1'b0;
        next_busy_cnt = busy_cnt;
        if (busy_cnt != '0) begin
            next_busy_cnt = busy_cnt - 1'b1;
        end
        if (start) begin
            next_st = S_RX;
            next_kind = K_DEV;
            next_cnt = '0;
            next_oe = 1'b0;
            next_have = 1'b0;
        end else if (stop) begin
            // wp is looked at only here, so a later change cannot touch the cycle
            if (have_data && !wp_s && busy_cnt == '0) begin
                next_busy_cnt = BC_W'(WRITE_CYCLES);
            end
            next_st = S_IDLE;
            next_oe = 1'b0;
            next_have = 1'b0;
        end else begin
            unique case (st)
                S_IDLE: begin
                end
                S_RX: begin
                    if (rise) begin
                        next_sh = {sh[6:0], sda};
                        next_cnt = cnt + 1'b1;
                    end else if (fall && cnt == SEAC_ACK_BIT) begin
                        next_cnt = '0;
                        next_st = S_RXACK;
                        next_oe = 1'b1;
                        unique case (kind)
                            K_DEV: begin
                                if (match && busy_cnt == '0) begin
                                    next_rw = sh[0];
                                    next_kind = K_HI;
                                    if (!sh[0]) begin
                                        next_pmask = '0;
                                    end
                                end else begin
                                    next_st = S_IDLE;
                                    next_oe = 1'b0;
                                end
                            end
                            K_HI: begin
                                next_addr = {sh[3:0], addr[7:0]};
                                next_kind = K_LO;
                            end
                            K_LO: begin
                                next_addr = {addr[11:8], sh};
                                next_kind = K_DATA;
                            end
                            K_DATA: begin
                                pbuf_we = 1'b1;
                                next_pmask[addr[SEAC_PAGE_W-1:0]] = 1'b1;
                                next_prow = addr[SEAC_ADDR_W-1:SEAC_PAGE_W];
                                next_addr[SEAC_PAGE_W-1:0] = addr[SEAC_PAGE_W-1:0] + 1'b1;
                                next_have = 1'b1;
                            end
                        endcase
                    end
                end
                S_RXACK: begin
                    if (fall) begin
                        if (rw && kind == K_HI) begin
                            next_sh = rd_byte;
                            next_oe = ~rd_byte[7];
                            next_addr = addr + 1'b1;
                            next_cnt = 4'h1;
                            next_st = S_TX;
                        end else begin
                            next_oe = 1'b0;
                            next_st = S_RX;
                        end
                    end
                end
                S_TX: begin
                    if (fall) begin
                        if (cnt == SEAC_ACK_BIT) begin
                            next_oe = 1'b0;
                            next_st = S_TXACK;
                        end else begin
                            next_oe = ~sh[6];
                            next_sh = {sh[6:0], 1'b0};
                            next_cnt = cnt + 1'b1;
                        end
                    end
                end
                S_TXACK: begin
                    if (rise) begin
                        next_more = ~sda;
                    end else if (fall) begin
                        if (more) begin
                            next_sh = rd_byte;
                            next_oe = ~rd_byte[7];
                            next_addr = addr + 1'b1;
                            next_cnt = 4'h1;
                            next_st = S_TX;
                        end else begin
                            next_st = S_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s1 <= SEAC_SYNC_RST;
            s2 <= SEAC_SYNC_RST;
            s3 <= 2'h3;
            st <= S_IDLE;
            kind <= K_DEV;
            cnt <= '0;
            sh <= '0;
            addr <= '0;
            rw <= 1'b0;
            more <= 1'b0;
            have_data <= 1'b0;
            sda_oe <= 1'b0;
            busy_cnt <= '0;
            pmask <= '0;
            prow <= '0;
            write_busy <= 1'b0;
        end else begin
            s1 <= {select_bit_two, select_bit_one, select_bit_zero, wp, link.sda, link.scl};
            s2 <= s1;
            s3 <= s2[1:0];
            st <= next_st;
            kind <= next_kind;
            cnt <= next_cnt;
            sh <= next_sh;
            addr <= next_addr;
            rw <= next_rw;
            more <= next_more;
            have_data <= next_have;
            sda_oe <= next_oe;
            busy_cnt <= next_busy_cnt;
            pmask <= next_pmask;
            prow <= next_prow;
            write_busy <= (next_busy_cnt != '0);
        end
    end

    // page commits one entry per cycle in the last page-count cycles of the write
    // plain always: the initial fill above is a second writer of the array
    always @(posedge sys_clk) begin
        if (pbuf_we) begin
            pbuf[addr[SEAC_PAGE_W-1:0]] <= sh;
        end
        if (busy_cnt != '0 && busy_cnt <= PAGE_CNT && pmask[cidx]) begin
            mem[{prow, cidx}] <= pbuf[cidx];
        end
    end
endmodule

// ===== tb/seac_assertions.sv
// checker on the link wires and the write cycle
// assumes one sys_clk domain; instantiated beside the link
`timescale 1ns/1ps
module seac_assertions #(
    parameter int WRITE_CYCLES = 200
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic m_sda_oe,
    input wire logic d_sda_oe,
    input wire logic sda,
    input wire logic wp,
    input wire logic write_busy
);
    logic [15:0] busy_cnt;
    logic [15:0] next_busy_cnt;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    always_comb begin
        next_busy_cnt = write_busy ? busy_cnt + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy_cnt <= 16'h0000;
        end else begin
            busy_cnt <= next_busy_cnt;
        end
    end
    AST_BUSY_QUIET: assert property (write_busy |-> !d_sda_oe)
        else $error("eeprom drives sda during write cycle");
    AST_BUSY_HOLD: assert property ($rose(write_busy) |=> write_busy [*8])
        else $error("write cycle ended early");
    // tolerance of one cycle either side of WRITE_CYCLES
    AST_BUSY_LEN: assert property ($fell(write_busy) |->
        busy_cnt >= WRITE_CYCLES - 1 && busy_cnt <= WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
    AST_LAUNCH_AT_STOP: assert property ($rose(write_busy) |-> scl && sda)
        else $error("write cycle not launched at stop");
    AST_WP_BLOCKS: assert property ($rose(write_busy) |-> !$past(wp, 6))
        else $error("write cycle while protected");
    AST_DEV_EDGE: assert property ($changed(d_sda_oe) |-> !scl)
        else $error("eeprom changes sda while scl high");
    AST_START_FORM: assert property ($fell(sda) && scl |-> m_sda_oe)
        else $error("start not made by host");
    AST_SCL_HIGH: assert property ($rose(scl) |=> scl [*7])
        else $error("scl high phase too short");
    AST_SDA_WIRE: assert property (scl |-> !(m_sda_oe && d_sda_oe))
        else $error("both ends drive sda while scl high");
endmodule

// ===== tb/seac_bench.sv
// bench: host and eeprom ends joined by the link, memory model
// assumes seac_pkg; the last read stalls so the fifo fills up
`timescale 1ns/1ps
module seac_bench;
    import seac_pkg::*;
    // long enough that the first poll after a write is refused
    localparam int WCYC = 1000;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic wp = 1'b0;
    logic [2:0] sel = 3'h5;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic cmd_read = 1'b0;
    logic [11:0] cmd_addr = 12'h000;
    logic [7:0] cmd_wdata = 8'h00;
    logic [7:0] cmd_count = 8'h01;
    logic rd_valid;
    logic rd_ready = 1'b0;
    logic [7:0] rd_data;
    logic write_busy;
    logic stall = 1'b0;
    logic busy_seen = 1'b0;
    int seed = 32'he553;
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    int mem [SEAC_DEPTH];
    int exp_q [$];
    seac_link_if lnk();
    always #2 sys_clk = ~sys_clk;
    seac_host #(.PHASE_CYCLES(8), .FIFO_DEPTH(16), .SELECT(3'h5)) i_seac_host (
        .sys_clk(sys_clk), .resetn(resetn), .link(lnk), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_count(cmd_count), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data));
    seac_dev #(.WRITE_CYCLES(WCYC)) i_seac_dev (
        .sys_clk(sys_clk), .resetn(resetn), .link(lnk), .wp(wp),
        .select_bit_zero(sel[0]), .select_bit_one(sel[1]), .select_bit_two(sel[2]),
        .write_busy(write_busy));
    seac_assertions #(.WRITE_CYCLES(WCYC)) i_seac_assertions (
        .sys_clk(sys_clk), .resetn(resetn), .scl(lnk.scl), .m_sda_oe(lnk.m_sda_oe),
        .d_sda_oe(lnk.d_sda_oe), .sda(lnk.sda), .wp(wp), .write_busy(write_busy));
    task automatic check(string what, int e, logic [7:0] g);
        checks++;
        if (g !== 8'(e)) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, e, g);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors++;
            test_done();
        end
        if (write_busy === 1'b1) busy_seen <= 1'b1;
        if (rd_valid === 1'b1 && rd_ready === 1'b1) check("rd_data", exp_q.pop_front(), rd_data);
        #1 rd_ready = stall ? 1'b0 : 1'($random(seed));
    end
    // p protects the write, tog raises wp once the cycle runs
    task automatic do_cmd(bit rd, logic [11:0] a, logic [7:0] d, int n, bit p, bit tog);
        int k = 0;
        cmd_read = rd;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_count = 8'(n);
        wp = p;
        busy_seen = 1'b0;
        cmd_valid = 1'b1;
        do @(posedge sys_clk); while (cmd_ready !== 1'b1);
        #1 cmd_valid = 1'b0;
        for (int i = 0; i < n && rd; i++) exp_q.push_back(mem[(a + i) % SEAC_DEPTH]);
        if (!rd && !p) mem[a] = d;
        do begin
            @(posedge sys_clk);
            #1 k++;
            if (k == 7000) stall = 1'b0;
            if (tog && write_busy === 1'b1) wp = 1'b1;
        end while (cmd_ready !== 1'b1 && k < 60000);
        check("write_busy", !rd && !p, busy_seen);
        wp = 1'b0;
    endtask
    initial begin
        logic [11:0] wa [4];
        for (int i = 0; i < SEAC_DEPTH; i++) mem[i] = 255;
        repeat (12) @(posedge sys_clk);
        #1 resetn = 1'b1;
        do_cmd(1'b1, 12'($random(seed)), 8'h00, 3, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wa[i] = 12'($random(seed));
            do_cmd(1'b0, wa[i], 8'($random(seed)), 1, i == 2, i == 1);
        end
        for (int i = 0; i < 4; i++) do_cmd(1'b1, wa[i], 8'h00, 1, 1'b0, 1'b0);
        do_cmd(1'b1, 12'hffe, 8'h00, 4, 1'b0, 1'b0);
        stall = 1'b1;
        do_cmd(1'b1, 12'($random(seed)), 8'h00, 20, 1'b0, 1'b0);
        repeat (50) @(posedge sys_clk);
        check("pending", 0, 8'(exp_q.size()));
        test_done();
    end
endmodule
